// *** verilog/sst_pkg.sv ***
package sst_pkg;

  // ***********************************
  // Control register field positions
  // ***********************************
  localparam int CTL_FORCE_ZERO    = 0;
  localparam int CTL_WSEL_LO       = 1;
  localparam int CTL_WSEL_HI       = 3;
  localparam int CTL_WIDTH_ARM     = 4;
  localparam int CTL_QSEL_LO       = 5;
  localparam int CTL_QSEL_HI       = 7;
  localparam int CTL_TEST_QUAD_A   = 8;
  localparam int CTL_TEST_QUAD_B   = 9;
  localparam int CTL_LOOP_LO       = 11;
  localparam int CTL_LOOP_HI       = 15;

  // ***********************************
  // Status buffer field positions
  // ***********************************
  localparam int STS_COUNT_LO      = 0;
  localparam int STS_COUNT_HI      = 7;
  localparam int STS_CARRY         = 8;
  localparam int STS_POLARITY      = 9;
  localparam int STS_BUSY_N        = 10;
  localparam int STS_LOOP_LO       = 11;
  localparam int STS_LOOP_HI       = 15;

  // ***********************************
  // Data bus placement and sizes
  // ***********************************
  localparam int BUS_LANE_LO       = 16;
  localparam int BUS_LANE_HI       = 31;
  localparam int REG_WIDTH         = 16;
  localparam int NUM_JOINTS        = 6;
  localparam int NUM_LOOPS         = 5;
  localparam int SEL_WIDTH         = 3;

  // ***********************************
  // Encoder select codes and reset values
  // ***********************************
  localparam logic [2:0]  QSEL_ALL     = 3'h0;
  localparam logic [2:0]  QSEL_NORMAL  = 3'h7;
  localparam logic [15:0] CTL_RESET    = 16'h00E1;
  localparam logic [8:0]  COUNT_RESET  = 9'h000;

endpackage : sst_pkg

// *** verilog/sst_quad_mux.sv ***
`timescale 1ns/1ps
module sst_quad_mux
  import sst_pkg::*;
#(
  parameter int JOINTS = 6
)
(
  input  wire logic              ref_clk,
  input  wire logic              rst,
  input  wire logic [2:0]        quadJointSel,
  input  wire logic              testQuadA,
  input  wire logic              testQuadB,
  input  wire logic [JOINTS-1:0] robotQuadA,
  input  wire logic [JOINTS-1:0] robotQuadB,
  output logic      [JOINTS-1:0] servoQuadInA,
  output logic      [JOINTS-1:0] servoQuadInB
);

  // ***********************************
  // Select decode
  // ***********************************
  function automatic logic [JOINTS-1:0] sst_decode(input logic [2:0] code);
    logic [JOINTS-1:0] sel;
    sel = '0;
    if (code == QSEL_ALL)
      sel = '1;
    else if (code != QSEL_NORMAL)
      sel[code - 3'h1] = 1'b1;
    return sel;
  endfunction : sst_decode

  logic [JOINTS-1:0] jointMuxSelect;

  assign jointMuxSelect = sst_decode(quadJointSel);

  // ***********************************
  // Registered output mux
  // ***********************************
  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      servoQuadInA <= '0;
      servoQuadInB <= '0;
    end
    else
    begin
      for (int j = 0; j < JOINTS; j++)
      begin
        servoQuadInA[j] <= jointMuxSelect[j] ? testQuadA : robotQuadA[j];
        servoQuadInB[j] <= jointMuxSelect[j] ? testQuadB : robotQuadB[j];
      end
    end
  end

endmodule : sst_quad_mux

// *** verilog/sst_width_meter.sv ***
`timescale 1ns/1ps
module sst_width_meter
  import sst_pkg::*;
#(
  parameter int CW = 8
)
(
  input  wire logic        ref_clk,
  input  wire logic        rst,
  input  wire logic        arm,
  input  wire logic        pulseIn,
  output logic      [CW:0] widthCount,
  output logic             widthBusyN
);

  typedef enum logic [1:0] {IDLE, WAIT_RISE, COUNTING, DONE} sst_state_t;

  sst_state_t state_r;
  logic       sync1_r;
  logic       sync2_r;
  logic       prev_r;
  logic       arm_r;
  logic       armRise;
  logic       pulseRise;
  logic       pulseFall;

  assign armRise   = arm & ~arm_r;
  assign pulseRise = sync2_r & ~prev_r;
  assign pulseFall = ~sync2_r & prev_r;

  // ***********************************
  // Pulse synchroniser
  // ***********************************
  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      sync1_r <= 1'b0;
      sync2_r <= 1'b0;
      prev_r  <= 1'b0;
      arm_r   <= 1'b0;
    end
    else
    begin
      sync1_r <= pulseIn;
      sync2_r <= sync1_r;
      prev_r  <= sync2_r;
      arm_r   <= arm;
    end
  end

  // ***********************************
  // Start and stop sequencing
  // ***********************************
  always_ff @(posedge ref_clk)
  begin
    if (rst)
      state_r <= IDLE;
    else if (!arm)
      state_r <= IDLE;
    else if (armRise)
      state_r <= WAIT_RISE;
    else
    begin
      case (state_r)
        WAIT_RISE:
          if (sync2_r && !prev_r)
            state_r <= COUNTING;
        COUNTING:
          if (!sync2_r && prev_r)
            state_r <= DONE;
        DONE:
          state_r <= DONE;
        default:
          state_r <= IDLE;
      endcase
    end
  end

  // ***********************************
  // Width counter with carry
  // ***********************************
  always_ff @(posedge ref_clk)
  begin
    if (rst)
      widthCount <= COUNT_RESET;
    else if (armRise)
      widthCount <= COUNT_RESET;
    else if (arm && ((state_r == WAIT_RISE && pulseRise) || (state_r == COUNTING && !pulseFall)))
      widthCount <= widthCount + (CW+1)'(1);
  end

  always_ff @(posedge ref_clk)
  begin
    if (rst)
      widthBusyN <= 1'b1;
    else
      widthBusyN <= !(arm && !armRise && (state_r == WAIT_RISE || state_r == COUNTING)
                      && !(state_r == COUNTING && !sync2_r && prev_r));
  end

endmodule : sst_width_meter

// *** verilog/sst_self_test.sv ***
`timescale 1ns/1ps
// Contract
// - Codes 001-110 route test levels to one joint
// - Code 000 drives test levels to all
// - Code 111 passes robot encoder straight through
// - Decode six per-joint mux selects
// - First rising edge after arming starts count
// - Next falling edge stops and holds count
// - Counter clocked by servo controller clock
// - Eight-bit count on status 0-7, carry bit 8
// - Active-low busy on status bit 10
// - Control bits 1-3 pick measured joint
// - Selected joint sign on status bit 9
// - Control bit 0 forces drive to zero
// - Control bit 4 arms width measurement
// - Bits 5-7 select, 8-9 test levels, 10 unused
// - Loop bits 11-15 out, returns in status
// - Both registers on data bus upper half
module sst_self_test
  import sst_pkg::*;
#(
  parameter int JOINTS = NUM_JOINTS,
  parameter int CW     = 8
)
(
  input  wire logic              ref_clk,
  input  wire logic              rst,
  input  wire logic [31:0]       procDataIn,
  input  wire logic              ctlWrite,
  input  wire logic              statusRead,
  output logic      [31:0]       procDataOut,
  output logic                   procDataOe,
  input  wire logic [JOINTS-1:0] robotQuadA,
  input  wire logic [JOINTS-1:0] robotQuadB,
  output logic      [JOINTS-1:0] servoQuadInA,
  output logic      [JOINTS-1:0] servoQuadInB,
  input  wire logic [JOINTS-1:0] servoPulse,
  input  wire logic [JOINTS-1:0] servoSign,
  output logic      [JOINTS-1:0] drivePulse,
  output logic      [JOINTS-1:0] driveSign,
  output logic      [4:0]        loopOut,
  input  wire logic [4:0]        loopIn
);

  // ***********************************
  // Control register
  // ***********************************
  logic [15:0]   selfTestControl_r;
  logic [15:0]   selfTestStatus;
  logic [2:0]    widthJointSel;
  logic [CW:0]   widthCount;
  logic          widthBusyN;
  logic          pulseSel;
  logic          drivePolaritySeen;

  always_ff @(posedge ref_clk)
  begin
    if (rst)
      selfTestControl_r <= CTL_RESET;
    else if (ctlWrite)
      selfTestControl_r <= procDataIn[BUS_LANE_HI:BUS_LANE_LO];
  end

  assign widthJointSel = selfTestControl_r[CTL_WSEL_HI:CTL_WSEL_LO];

  // ***********************************
  // Encoder path multiplexer
  // ***********************************
  sst_quad_mux #(
    .JOINTS (JOINTS)
  ) uQuadMux (
    .ref_clk      (ref_clk),
    .rst          (rst),
    .quadJointSel (selfTestControl_r[CTL_QSEL_HI:CTL_QSEL_LO]),
    .testQuadA    (selfTestControl_r[CTL_TEST_QUAD_A]),
    .testQuadB    (selfTestControl_r[CTL_TEST_QUAD_B]),
    .robotQuadA   (robotQuadA),
    .robotQuadB   (robotQuadB),
    .servoQuadInA (servoQuadInA),
    .servoQuadInB (servoQuadInB)
  );

  // ***********************************
  // Joint selection for width monitor
  // ***********************************
  function automatic logic sst_pick(input logic [JOINTS-1:0] v, input logic [2:0] s);
    sst_pick = (int'(s) < JOINTS) ? v[s] : 1'b0;
  endfunction : sst_pick

  assign pulseSel          = sst_pick(servoPulse, widthJointSel);
  assign drivePolaritySeen = sst_pick(servoSign, widthJointSel);

  sst_width_meter #(
    .CW (CW)
  ) uWidthMeter (
    .ref_clk    (ref_clk),
    .rst        (rst),
    .arm        (selfTestControl_r[CTL_WIDTH_ARM]),
    .pulseIn    (pulseSel),
    .widthCount (widthCount),
    .widthBusyN (widthBusyN)
  );

  // ***********************************
  // Drive gating toward robot
  // ***********************************
  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      drivePulse <= '0;
      driveSign  <= '0;
    end
    else if (selfTestControl_r[CTL_FORCE_ZERO])
    begin
      drivePulse <= '0;
      driveSign  <= '0;
    end
    else
    begin
      drivePulse <= servoPulse;
      driveSign  <= servoSign;
    end
  end

  // ***********************************
  // Cable loopback
  // ***********************************
  always_ff @(posedge ref_clk)
  begin
    if (rst)
      loopOut <= '0;
    else
      loopOut <= selfTestControl_r[CTL_LOOP_HI:CTL_LOOP_LO];
  end

  // ***********************************
  // Status buffer and read port
  // ***********************************
  always_comb
  begin
    selfTestStatus                             = '0;
    selfTestStatus[STS_COUNT_HI:STS_COUNT_LO]  = widthCount[7:0];
    selfTestStatus[STS_CARRY]                  = widthCount[CW];
    selfTestStatus[STS_POLARITY]               = drivePolaritySeen;
    selfTestStatus[STS_BUSY_N]                 = widthBusyN;
    selfTestStatus[STS_LOOP_HI:STS_LOOP_LO]    = loopIn;
  end

  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      procDataOut <= '0;
      procDataOe  <= 1'b0;
    end
    else
    begin
      procDataOe  <= statusRead;
      procDataOut <= statusRead ? {selfTestStatus, 16'h0000} : 32'h00000000;
    end
  end

endmodule : sst_self_test

// *** bench/sst_self_test_sva.sv ***
`timescale 1ns/1ps
module sst_self_test_sva
  import sst_pkg::*;
#(
  parameter int JOINTS = 6
)
(
  input wire logic              ref_clk,
  input wire logic              rst,
  input wire logic [31:0]       procDataIn,
  input wire logic              ctlWrite,
  input wire logic              statusRead,
  input wire logic [31:0]       procDataOut,
  input wire logic              procDataOe,
  input wire logic [JOINTS-1:0] robotQuadA,
  input wire logic [JOINTS-1:0] robotQuadB,
  input wire logic [JOINTS-1:0] servoQuadInA,
  input wire logic [JOINTS-1:0] servoQuadInB,
  input wire logic [JOINTS-1:0] servoPulse,
  input wire logic [JOINTS-1:0] servoSign,
  input wire logic [JOINTS-1:0] drivePulse,
  input wire logic [JOINTS-1:0] driveSign,
  input wire logic [4:0]        loopOut,
  input wire logic [4:0]        loopIn
);
  // *****
  // Shadow of the control register
  // *****
  logic [15:0]       ctl_r;
  logic [JOINTS-1:0] expA;
  logic [JOINTS-1:0] expB;

  always_ff @(posedge ref_clk)
  begin
    if (rst)
      ctl_r <= CTL_RESET;
    else if (ctlWrite)
      ctl_r <= procDataIn[31:16];
  end

  always_comb
  begin
    for (int j = 0; j < JOINTS; j++)
    begin
      expA[j] = (ctl_r[7:5] == 3'h0 || ctl_r[7:5] == 3'(j + 1)) ? ctl_r[8] : robotQuadA[j];
      expB[j] = (ctl_r[7:5] == 3'h0 || ctl_r[7:5] == 3'(j + 1)) ? ctl_r[9] : robotQuadB[j];
    end
  end

  // *****
  // Assertions
  // *****
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (rst);

  sequence armQuiet;
    ctlWrite && procDataIn[20] && !ctl_r[4] && servoPulse == '0 ##1 (servoPulse == '0) [*3];
  endsequence

  a_loop_follow: assert property (!$past(rst) |-> loopOut == $past(ctl_r[15:11]))
    else $error("loop output differs from control");
  a_drive_zero: assert property (!$past(rst) && $past(ctl_r[0]) |-> drivePulse == '0 && driveSign == '0)
    else $error("drive not forced to zero");
  a_drive_pass: assert property (!$past(rst) && !$past(ctl_r[0]) |->
                                 driveSign == $past(servoSign) && drivePulse == $past(servoPulse))
    else $error("drive sign not passed");
  a_quad_route_a: assert property (!$past(rst) |-> servoQuadInA == $past(expA))
    else $error("channel A routing wrong");
  a_quad_route_b: assert property (!$past(rst) |-> servoQuadInB == $past(expB))
    else $error("channel B routing wrong");
  a_read_answer: assert property (statusRead |=> procDataOe && procDataOut[15:0] == 16'h0000)
    else $error("status read answer wrong");
  a_read_idle: assert property (!statusRead |=> !procDataOe && procDataOut == '0)
    else $error("bus driven without read");
  a_loop_status: assert property (statusRead |=> procDataOut[31:27] == $past(loopIn))
    else $error("loop returns not in status");
  a_sign_sel: assert property (statusRead && ctl_r[3:1] < 3'h6 |=> procDataOut[25] == $past(servoSign[ctl_r[3:1]]))
    else $error("selected sign wrong");
  a_arm_clear: assert property (armQuiet ##0 statusRead |=> !procDataOut[26] && procDataOut[24:16] == 9'h000)
    else $error("arming did not clear count");
endmodule : sst_self_test_sva

// *** bench/sst_far_side.sv ***
`timescale 1ns/1ps
module sst_far_side
  import sst_pkg::*;
#(
  parameter logic [5:0] SIGNS = 6'h2A
)
(
  input  wire logic       ref_clk,
  input  wire logic [4:0] loopOut,
  output logic      [4:0] loopIn,
  output logic      [5:0] servoPulse,
  output logic      [5:0] servoSign
);
  // *****
  // Cable ends tied together, servo controller outputs
  // *****
  assign loopIn = loopOut;
  assign servoSign = SIGNS;

  initial servoPulse = '0;

  task automatic pulse(input int j, input int w);
    @(posedge ref_clk);
    servoPulse[j] <= 1'b1;
    repeat (w) @(posedge ref_clk);
    servoPulse[j] <= 1'b0;
  endtask : pulse
endmodule : sst_far_side

// *** bench/test_servo_path_self_test.sv ***
`timescale 1ns/1ps
module test_servo_path_self_test
  import sst_pkg::*;
;
  localparam logic [5:0] SGN = 6'h2A;
  localparam logic [1:0] QSEQ [4] = '{2'h0, 2'h1, 2'h3, 2'h2};
  logic        ref_clk;
  logic        rst;
  logic [31:0] procDataIn;
  logic        ctlWrite;
  logic        statusRead;
  logic [31:0] procDataOut;
  logic        procDataOe;
  logic [5:0]  robotQuadA;
  logic [5:0]  robotQuadB;
  logic [5:0]  servoQuadInA;
  logic [5:0]  servoQuadInB;
  logic [5:0]  servoPulse;
  logic [5:0]  servoSign;
  logic [5:0]  drivePulse;
  logic [5:0]  driveSign;
  logic [4:0]  loopOut;
  logic [4:0]  loopIn;
  logic [15:0] sts;
  logic [5:0]  exA;
  int          errTotal;
  int          numChecks;
  int          wid [6] = '{3, 7, 40, 255, 256, 100};

  sst_self_test dut (
    .ref_clk      (ref_clk),
    .rst          (rst),
    .procDataIn   (procDataIn),
    .ctlWrite     (ctlWrite),
    .statusRead   (statusRead),
    .procDataOut  (procDataOut),
    .procDataOe   (procDataOe),
    .robotQuadA   (robotQuadA),
    .robotQuadB   (robotQuadB),
    .servoQuadInA (servoQuadInA),
    .servoQuadInB (servoQuadInB),
    .servoPulse   (servoPulse),
    .servoSign    (servoSign),
    .drivePulse   (drivePulse),
    .driveSign    (driveSign),
    .loopOut      (loopOut),
    .loopIn       (loopIn)
  );

  sst_far_side #(.SIGNS(SGN)) far (
    .ref_clk    (ref_clk),
    .loopOut    (loopOut),
    .loopIn     (loopIn),
    .servoPulse (servoPulse),
    .servoSign  (servoSign)
  );

  initial
  begin
    ref_clk = 1'b0;
    forever #25 ref_clk = ~ref_clk;
  end

  // *****
  // Access tasks
  // *****
  task automatic tally_and_finish;
    if (errTotal == 0 && numChecks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : tally_and_finish

  task automatic chk(input string n, input logic [15:0] e, input logic [15:0] s);
    numChecks++;
    if (s !== e)
    begin
      $display("mismatch %s exp %h got %h", n, e, s);
      errTotal++;
    end
  endtask : chk

  task automatic wr(input logic [15:0] v);
    @(posedge ref_clk);
    procDataIn <= {v, 16'h0000};
    ctlWrite   <= 1'b1;
    @(posedge ref_clk);
    ctlWrite <= 1'b0;
  endtask : wr

  task automatic rd;
    @(posedge ref_clk);
    statusRead <= 1'b1;
    @(posedge ref_clk);
    statusRead <= 1'b0;
    #1;
    sts = procDataOe ? procDataOut[31:16] : 16'hXXXX;
  endtask : rd

  // *****
  // Test sequence
  // *****
  initial
  begin
    rst = 1'b1;
    procDataIn = '0;
    ctlWrite = 1'b0;
    statusRead = 1'b0;
    robotQuadA = 6'h00;
    robotQuadB = 6'h3F;
    errTotal = 0;
    numChecks = 0;
    repeat (10) @(posedge ref_clk);
    rst <= 1'b0;
    rd;
    chk("status", 16'h0400, sts);
    for (int c = 0; c < 8; c++)
    begin
      wr(16'h0101 | 16'(c) << 5);
      repeat (2) @(posedge ref_clk);
      #1;
      exA = (c == 0) ? 6'h3F : (c == 7) ? 6'h00 : 6'(1 << (c - 1));
      chk("quadA", 16'(exA), 16'(servoQuadInA));
      chk("quadB", 16'(exA ^ 6'h3F), 16'(servoQuadInB));
    end
    for (int q = 0; q < 4; q++)
    begin
      wr(16'h0061 | 16'(QSEQ[q]) << 8);
      repeat (2) @(posedge ref_clk);
      #1;
      chk("stepA", 16'(QSEQ[q][0]) << 2, 16'(servoQuadInA));
      chk("stepB", 16'h003B | 16'(QSEQ[q][1]) << 2, 16'(servoQuadInB));
    end
    for (int k = 0; k < 5; k++)
    begin
      wr(16'h00E0 | 16'h0800 << k);
      rd;
      chk("loop", 16'h0400 | 16'h0800 << k, sts);
      chk("drive", 16'(SGN), 16'(driveSign));
    end
    far.pulse(1, 4);
    #1;
    chk("pulse", 16'h0002, 16'(drivePulse));
    for (int j = 0; j < 6; j++)
    begin
      wr(16'h00E1 | 16'(j) << 1);
      wr(16'h00F1 | 16'(j) << 1);
      repeat (1) @(posedge ref_clk);
      rd;
      chk("armed", 16'(SGN[j]) << 9, sts);
      chk("drive0", 16'h0000, 16'(driveSign));
      far.pulse(j, wid[j]);
      repeat (6) @(posedge ref_clk);
      rd;
      chk("width", 16'h0400 | 16'(SGN[j]) << 9 | 16'(wid[j]), sts);
    end
    far.pulse(5, 9);
    repeat (6) @(posedge ref_clk);
    rd;
    chk("hold", 16'h0600 | 16'(wid[5]), sts);
    tally_and_finish;
  end

  initial
  begin
    repeat (100000) @(posedge ref_clk);
    errTotal++;
    tally_and_finish;
  end
endmodule : test_servo_path_self_test

bind sst_self_test sst_self_test_sva #(.JOINTS(JOINTS)) u_sva (
  .ref_clk      (ref_clk),
  .rst          (rst),
  .procDataIn   (procDataIn),
  .ctlWrite     (ctlWrite),
  .statusRead   (statusRead),
  .procDataOut  (procDataOut),
  .procDataOe   (procDataOe),
  .robotQuadA   (robotQuadA),
  .robotQuadB   (robotQuadB),
  .servoQuadInA (servoQuadInA),
  .servoQuadInB (servoQuadInB),
  .servoPulse   (servoPulse),
  .servoSign    (servoSign),
  .drivePulse   (drivePulse),
  .driveSign    (driveSign),
  .loopOut      (loopOut),
  .loopIn       (loopIn)
);
